// ===== dpm_pkg.sv
/*
 * package for the dual port I/O mux: register offsets, field positions,
 * reset values and mode enumeration.
 * assumes a 32-bit Avalon-MM slave, one register per aligned word.
 */
package dpm_pkg;
  localparam logic [4:0] OFF_C_PINS = 5'h00;
  localparam logic [4:0] OFF_C_LATCH = 5'h04;
  localparam logic [4:0] OFF_C_DIR = 5'h08;
  localparam logic [4:0] OFF_D_PINS = 5'h0c;
  localparam logic [4:0] OFF_D_LATCH = 5'h10;
  localparam logic [4:0] OFF_D_DIR = 5'h14;
  localparam logic [4:0] OFF_SLAVE_CTL = 5'h18;
  localparam logic [4:0] OFF_MEM_CTL = 5'h1c;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // slave port control fields
  localparam int SP_IN_FULL = 7;
  localparam int SP_OUT_FULL = 6;
  localparam int SP_IN_OVF = 5;
  localparam int SP_MODE = 4;
  // memory bus control fields
  localparam int MB_DISABLE = 7;
  localparam int MB_WAIT_HI = 5;
  localparam int MB_WAIT_LO = 4;
  localparam int MB_WM_HI = 1;
  localparam int MB_WM_LO = 0;
  localparam logic [7:0] MEM_CTL_MASK = 8'hb3;
  localparam logic [7:0] SP_CTL_WMASK = 8'h10;
  typedef enum logic [1:0] {
    DPM_MODE_GPIO,
    DPM_MODE_SYSBUS,
    DPM_MODE_SLAVE
  } dpm_mode_t;
endpackage

// ===== dpm_pad_if.sv
/*
 * interface carrying one 8-bit port's pad control between core and pad mux.
 * assumes both ends run on sys_clk.
 */
`timescale 1ns/1ps
interface dpm_pad_if;
  logic [7:0] dir;
  logic [7:0] latch;
  logic [7:0] alt_oe;
  logic [7:0] alt_out;
  logic [7:0] alt_sel;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  modport core (output dir, output latch, output alt_oe, output alt_out, output alt_sel,
    input pad_out, input pad_oe);
  modport mux (input dir, input latch, input alt_oe, input alt_out, input alt_sel,
    output pad_out, output pad_oe);
endinterface

// ===== dpm_pad_mux.sv
/*
 * pad mux for one 8-bit port: direction/latch or an overriding owner.
 * assumes override selects are stable per cycle; purely combinational.
 */
`timescale 1ns/1ps
module dpm_pad_mux (
  dpm_pad_if.mux pad
);
  // ************************************************
  // per-bit driver selection
  // ************************************************
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.alt_sel[i]) begin
        pad.pad_oe[i] = pad.alt_oe[i];
        pad.pad_out[i] = pad.alt_out[i];
      end else begin
        pad.pad_oe[i] = ~pad.dir[i];
        pad.pad_out[i] = pad.latch[i];
      end
    end
  end
endmodule

// ===== dpm_top.sv
/*
 * dual port I/O mux: port C with peripheral overrides, port D shared with
 * the external address/data bus and the parallel slave port.
 * assumes synchronous pin inputs and an Avalon-MM master on sys_clk.
 */
// Overview of operation
// - direction one makes the pin an input
// - direction zero drives the latch onto pin
// - latch reads return stored latch value
// - every reset sets all direction bits
// - latch keeps value across every reset
// - peripherals may force port C direction
// - overrides never change stored direction bits
// - channel 2 on C bit1 when select=1
// - C0 oscillator/timer clock, C2 channel 1
// - C3 serial clock, C4 serial data in
// - C5 serial out, C6/C7 serial unit
// - port D I/O with slave mode off and bus disabled or not active
// - active, enabled memory bus owns port D pins unless slave mode is on
// - slave mode makes port D parallel port
// - port D thresholds follow the mode
// - slave control flags bits 7..4, low zero
`timescale 1ns/1ps
module dpm_top
  import dpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  output logic port_d_ttl_sel,
  input wire logic compare2_pin_select,
  input wire logic [7:0] periph_c_en,
  input wire logic [7:0] periph_c_oe,
  input wire logic [7:0] periph_c_out,
  output logic compare_capture_ch2_in,
  input wire logic ext_mem_active,
  input wire logic ext_bus_oe,
  input wire logic [7:0] ext_bus_out,
  input wire logic slave_cs_b,
  input wire logic slave_rd_b,
  input wire logic slave_wr_b,
  output logic [7:0] slave_in_data,
  input wire logic slave_in_taken,
  input wire logic [7:0] slave_out_data,
  input wire logic slave_out_load
);
  import dpm_pkg::*;

  logic [7:0] c_latch_reg;
  logic [7:0] c_dir_reg;
  logic [7:0] d_latch_reg;
  logic [7:0] d_dir_reg;
  logic [7:0] mem_ctl_reg;
  logic sp_mode_reg;
  logic sp_in_full_reg;
  logic sp_out_full_reg;
  logic sp_in_ovf_reg;
  logic [7:0] sp_in_reg;
  logic [7:0] sp_out_reg;
  logic [7:0] sp_ctl_rd;
  logic rd_pend_reg;
  logic ext_wr_prev_reg;
  logic ext_rd_prev_reg;
  logic ext_wr;
  logic ext_rd;
  logic ext_wr_end;
  logic ext_rd_end;
  logic [31:0] rdata_next;
  dpm_mode_t d_mode;

  dpm_pad_if pad_c ();
  dpm_pad_if pad_d ();

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h00_0000, v};
  endfunction

  // ************************************************
  // Avalon-MM slave: one wait cycle on reads
  // ************************************************
  // reads register the data first so readdata comes from a flop
  assign avs_waitrequest = avs_read & ~rd_pend_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= avs_read & ~rd_pend_reg;
    end
  end

  always_comb begin
    rdata_next = UNMAPPED_DATA;
    case (avs_address)
      OFF_C_PINS: rdata_next = word8(port_c_in);
      OFF_C_LATCH: rdata_next = word8(c_latch_reg);
      OFF_C_DIR: rdata_next = word8(c_dir_reg);
      OFF_D_PINS: rdata_next = word8(port_d_in);
      OFF_D_LATCH: rdata_next = word8(d_latch_reg);
      OFF_D_DIR: rdata_next = word8(d_dir_reg);
      OFF_SLAVE_CTL: rdata_next = word8(sp_ctl_rd);
      OFF_MEM_CTL: rdata_next = word8(mem_ctl_reg);
      default: rdata_next = UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_pend_reg) begin
      avs_readdata <= rdata_next;
    end
  end

  // ************************************************
  // direction registers
  // ************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      c_dir_reg <= DIR_RESET;
      d_dir_reg <= DIR_RESET;
    end else if (avs_write) begin
      if (hit(avs_address, OFF_C_DIR)) begin
        c_dir_reg <= avs_writedata[7:0];
      end
      if (hit(avs_address, OFF_D_DIR)) begin
        d_dir_reg <= avs_writedata[7:0];
      end
    end
  end

  // ************************************************
  // output latches
  // ************************************************
  // no reset: contents survive every reset, unknown after power-up
  always_ff @(posedge sys_clk) begin
    if (avs_write && (hit(avs_address, OFF_C_PINS) || hit(avs_address, OFF_C_LATCH))) begin
      c_latch_reg <= avs_writedata[7:0];
    end
    if (avs_write && (hit(avs_address, OFF_D_PINS) || hit(avs_address, OFF_D_LATCH))) begin
      d_latch_reg <= avs_writedata[7:0];
    end
  end

  // ************************************************
  // memory bus control
  // ************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ctl_reg <= CTL_RESET;
    end else if (avs_write && hit(avs_address, OFF_MEM_CTL)) begin
      mem_ctl_reg <= avs_writedata[7:0] & MEM_CTL_MASK;
    end
  end

  // ************************************************
  // port D ownership
  // ************************************************
  always_comb begin
    if (sp_mode_reg) begin
      d_mode = DPM_MODE_SLAVE;
    end else if (!mem_ctl_reg[MB_DISABLE] && ext_mem_active) begin
      d_mode = DPM_MODE_SYSBUS;
    end else begin
      d_mode = DPM_MODE_GPIO;
    end
  end

  // port C is always Schmitt; only port D switches thresholds
  assign port_d_ttl_sel = (d_mode != DPM_MODE_GPIO);

  // ************************************************
  // parallel slave port
  // ************************************************
  assign ext_wr = ~slave_cs_b & ~slave_wr_b;
  assign ext_rd = ~slave_cs_b & ~slave_rd_b;
  assign ext_wr_end = ext_wr_prev_reg & ~ext_wr;
  assign ext_rd_end = ext_rd_prev_reg & ~ext_rd;
  assign slave_in_data = sp_in_reg;
  assign sp_ctl_rd = {sp_in_full_reg, sp_out_full_reg, sp_in_ovf_reg, sp_mode_reg, 4'h0};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_wr_prev_reg <= 1'b0;
      ext_rd_prev_reg <= 1'b0;
      sp_in_reg <= 8'h00;
      sp_out_reg <= 8'h00;
    end else begin
      ext_wr_prev_reg <= ext_wr & sp_mode_reg;
      ext_rd_prev_reg <= ext_rd & sp_mode_reg;
      if (sp_mode_reg && ext_wr) begin
        sp_in_reg <= port_d_in;
      end
      if (slave_out_load) begin
        sp_out_reg <= slave_out_data;
      end
    end
  end

  // hardware sets win over software clears
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_mode_reg <= 1'b0;
      sp_in_full_reg <= 1'b0;
      sp_out_full_reg <= 1'b0;
      sp_in_ovf_reg <= 1'b0;
    end else begin
      if (avs_write && hit(avs_address, OFF_SLAVE_CTL)) begin
        sp_mode_reg <= avs_writedata[SP_MODE];
        if (!avs_writedata[SP_IN_OVF]) begin
          sp_in_ovf_reg <= 1'b0;
        end
      end
      if (ext_wr_end) begin
        sp_in_full_reg <= 1'b1;
        if (sp_in_full_reg) begin
          sp_in_ovf_reg <= 1'b1;
        end
      end else if (slave_in_taken) begin
        sp_in_full_reg <= 1'b0;
      end
      if (slave_out_load) begin
        sp_out_full_reg <= 1'b1;
      end else if (ext_rd_end) begin
        sp_out_full_reg <= 1'b0;
      end
    end
  end

  // ************************************************
  // pad control
  // ************************************************
  assign pad_c.dir = c_dir_reg;
  assign pad_c.latch = c_latch_reg;
  assign pad_c.alt_sel = periph_c_en;
  assign pad_c.alt_oe = periph_c_oe;
  assign pad_c.alt_out = periph_c_out;
  // channel 2 appears on C bit 1 only with the select at its default one
  assign compare_capture_ch2_in = compare2_pin_select & port_c_in[1];

  assign pad_d.dir = d_dir_reg;
  assign pad_d.latch = d_latch_reg;
  assign pad_d.alt_sel = (d_mode == DPM_MODE_GPIO) ? 8'h00 : 8'hff;
  assign pad_d.alt_oe = (d_mode == DPM_MODE_SLAVE) ? {8{ext_rd}} : {8{ext_bus_oe}};
  assign pad_d.alt_out = (d_mode == DPM_MODE_SLAVE) ? sp_out_reg : ext_bus_out;

  dpm_pad_mux u_mux_c (
    .pad(pad_c)
  );

  dpm_pad_mux u_mux_d (
    .pad(pad_d)
  );

  assign port_c_out = pad_c.pad_out;
  assign port_c_oe = pad_c.pad_oe;
  assign port_d_out = pad_d.pad_out;
  assign port_d_oe = pad_d.pad_oe;

  // ************************************************
  // checks
  // ************************************************
  dir_reset_val_a: assert property (@(posedge sys_clk) $rose(rst_b) |->
    (c_dir_reg == DIR_RESET) && (d_dir_reg == DIR_RESET))
    else $error("direction not all ones after reset");
  input_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!periph_c_en[0] && c_dir_reg[0]) |-> !port_c_oe[0])
    else $error("input pin driven");
  output_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!periph_c_en[3] && !c_dir_reg[3]) |-> port_c_oe[3] && port_c_out[3] == c_latch_reg[3])
    else $error("output pin not latch");
  latch_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (avs_read && !rd_pend_reg && avs_address == OFF_C_LATCH) |=>
    avs_readdata[7:0] == $past(c_latch_reg))
    else $error("latch read wrong");
  pin_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (avs_write && avs_address == OFF_D_PINS) |=> d_latch_reg == $past(avs_writedata[7:0]))
    else $error("pin write missed latch");
  override_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!avs_write && periph_c_en != 8'h00) |=> $stable(c_dir_reg))
    else $error("override changed direction");
  ttl_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sp_mode_reg |-> port_d_ttl_sel)
    else $error("slave mode not ttl");
  ctl_low_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (avs_read && !rd_pend_reg && avs_address == OFF_SLAVE_CTL) |=> avs_readdata[3:0] == 4'h0)
    else $error("control low bits not zero");
  bus_owns_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!sp_mode_reg && !mem_ctl_reg[MB_DISABLE] && ext_mem_active) |->
    port_d_out == ext_bus_out)
    else $error("bus does not own port d");
  read_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (avs_read && !rd_pend_reg) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait cycle wrong");
  write_no_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  mem_ctl_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mem_ctl_reg & ~MEM_CTL_MASK) == 8'h00)
    else $error("reserved memory control bit set");
  gpio_owns_d_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!sp_mode_reg && mem_ctl_reg[MB_DISABLE]) |->
    !port_d_ttl_sel && port_d_oe == ~d_dir_reg)
    else $error("port d not gpio with bus disabled");
  slave_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sp_mode_reg && ext_rd) |-> port_d_oe == 8'hff && port_d_out == sp_out_reg)
    else $error("slave read not driving");
  slave_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sp_mode_reg && !ext_rd) |-> port_d_oe == 8'h00)
    else $error("slave port drives without read");
  slave_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sp_mode_reg && ext_wr) |=> sp_in_reg == $past(port_d_in))
    else $error("slave write not captured");
  in_full_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ext_wr_end |=> sp_in_full_reg)
    else $error("input full not set");
  overflow_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ext_wr_end && sp_in_full_reg) |=> sp_in_ovf_reg)
    else $error("overflow not flagged");
  out_full_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    slave_out_load |=> sp_out_full_reg)
    else $error("output full not set");
  override_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    periph_c_en[5] |-> port_c_oe[5] == periph_c_oe[5] && port_c_out[5] == periph_c_out[5])
    else $error("override not on pin");
endmodule

// ===== dpm_pins_model.sv
/* outside world of the port pins: pin levels and a parallel-port master.
   assumes the bench owns c_ext and calls psp from its main process. */
`timescale 1ns/1ps
module dpm_pins_model (
  input wire logic sys_clk,
  input wire logic [7:0] c_out,
  input wire logic [7:0] c_oe,
  input wire logic [7:0] d_out,
  input wire logic [7:0] d_oe,
  input wire logic [7:0] c_ext,
  output logic [7:0] c_in,
  output logic [7:0] d_in,
  output logic cs_b,
  output logic rd_b,
  output logic wr_b
);
  // ****
  // pins and strobes
  // ****
  logic [7:0] d_ext = 8'h00;
  assign c_in = (c_out & c_oe) | (c_ext & ~c_oe);
  assign d_in = (d_out & d_oe) | (d_ext & ~d_oe);
  initial {cs_b, rd_b, wr_b} = 3'h7;
  task automatic psp(input logic wr, input logic [7:0] d);
    @(posedge sys_clk);
    d_ext <= d;
    cs_b <= 1'b0;
    rd_b <= wr;
    wr_b <= !wr;
    repeat (3) @(posedge sys_clk);
    {cs_b, rd_b, wr_b} <= 3'h7;
    // released bus must not keep showing the byte
    d_ext <= ~d;
  endtask
endmodule

// ===== tb_top.sv
/* self-checking bench for dpm_top: register tasks, pin model, read queue.
   assumes one master on sys_clk and a pin model that answers at once. */
`timescale 1ns/1ps
module tb_top;
  import dpm_pkg::*;
  // ****
  // signals and instances
  // ****
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, port_d_ttl_sel, ch2_in, cs_b, rd_b, wr_b, w_q;
  logic [7:0] port_c_in, port_c_out, port_c_oe, port_d_in, port_d_out, port_d_oe, s_in;
  logic sel2 = 1'b1;
  logic [7:0] p_en = 8'h0, p_oe = 8'h0, p_out = 8'h0, c_ext = 8'h0;
  logic [7:0] bus_out = 8'h0, s_out = 8'h0, v, w;
  logic mem_act = 1'b0, bus_oe = 1'b0, taken = 1'b0, load = 1'b0;
  logic [31:0] seed = 32'h1df3f206;
  logic [31:0] rq[$];
  int fails = 0, checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  dpm_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_c_in(port_c_in), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
    .port_d_in(port_d_in), .port_d_out(port_d_out), .port_d_oe(port_d_oe),
    .port_d_ttl_sel(port_d_ttl_sel), .compare2_pin_select(sel2), .periph_c_en(p_en),
    .periph_c_oe(p_oe), .periph_c_out(p_out), .compare_capture_ch2_in(ch2_in),
    .ext_mem_active(mem_act), .ext_bus_oe(bus_oe), .ext_bus_out(bus_out),
    .slave_cs_b(cs_b), .slave_rd_b(rd_b), .slave_wr_b(wr_b), .slave_in_data(s_in),
    .slave_in_taken(taken), .slave_out_data(s_out), .slave_out_load(load));
  dpm_pins_model u_pins (.sys_clk(sys_clk), .c_out(port_c_out), .c_oe(port_c_oe),
    .d_out(port_d_out), .d_oe(port_d_oe), .c_ext(c_ext), .c_in(port_c_in),
    .d_in(port_d_in), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b));
  // ****
  // tasks
  // ****
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
    cmp_rd({24'h0, g}, {24'h0, e});
  endtask
  // sampled mid-cycle so the value is the one seen at the next rising edge
  always @(negedge sys_clk) begin
    w_q = avs_waitrequest;
    if (avs_read && w_q === 1'b0 && rq.size() > 0) begin
      cmp_rd(avs_readdata, rq.pop_front());
    end
  end
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (w_q !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      tally_and_finish();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFF_C_DIR, DIR_RESET);
    rd(OFF_D_DIR, DIR_RESET);
    rd(OFF_SLAVE_CTL, CTL_RESET);
    rd(5'h1e, 8'h00);
    @(negedge sys_clk);
    cmp_pin(port_c_oe, 8'h00);
    @(posedge sys_clk);
    seed = xs(seed);
    v = seed[7:0];
    w = seed[15:8];
    c_ext <= seed[23:16];
    wr(OFF_C_LATCH, v);
    wr(OFF_C_DIR, w);
    @(negedge sys_clk);
    cmp_pin(port_c_oe, ~w);
    cmp_pin(port_c_out & ~w, v & ~w);
    rd(OFF_C_LATCH, v);
    rd(OFF_C_PINS, (v & ~w) | (c_ext & w));
    wr(OFF_C_PINS, ~v);
    rd(OFF_C_LATCH, ~v);
    p_en <= 8'hff;
    p_oe <= seed[31:24];
    p_out <= v;
    @(negedge sys_clk);
    cmp_pin(port_c_oe, p_oe);
    cmp_pin(port_c_out & p_oe, v & p_oe);
    rd(OFF_C_DIR, w);
    p_en <= 8'h00;
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      sel2 <= s[0];
      @(negedge sys_clk);
      cmp_pin({7'h0, ch2_in}, {7'h0, port_c_in[1] & s[0]});
    end
    wr(OFF_MEM_CTL, 8'hff);
    rd(OFF_MEM_CTL, MEM_CTL_MASK);
    mem_act <= 1'b1;
    wr(OFF_D_PINS, ~v);
    rd(OFF_D_LATCH, ~v);
    wr(OFF_D_LATCH, v);
    wr(OFF_D_DIR, 8'h00);
    @(negedge sys_clk);
    cmp_pin(port_d_out, v);
    cmp_pin({7'h0, port_d_ttl_sel}, 8'h00);
    rd(OFF_D_PINS, v);
    @(posedge sys_clk);
    bus_oe <= 1'b1;
    bus_out <= w;
    wr(OFF_MEM_CTL, 8'h00);
    @(negedge sys_clk);
    cmp_pin(port_d_oe, 8'hff);
    cmp_pin(port_d_out, w);
    cmp_pin({7'h0, port_d_ttl_sel}, 8'h01);
    rd(OFF_D_LATCH, v);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFF_D_DIR, DIR_RESET);
    rd(OFF_D_LATCH, v);
    rd(OFF_C_LATCH, ~v);
    mem_act <= 1'b0;
    wr(OFF_SLAVE_CTL, 8'h10);
    u_pins.psp(1'b1, w);
    repeat (2) @(posedge sys_clk);
    cmp_pin(s_in, w);
    rd(OFF_SLAVE_CTL, 8'h90);
    u_pins.psp(1'b1, v);
    rd(OFF_SLAVE_CTL, 8'hb0);
    s_out <= v;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
    rd(OFF_SLAVE_CTL, 8'hf0);
    fork
      u_pins.psp(1'b0, 8'h00);
      begin
        repeat (3) @(negedge sys_clk);
        cmp_pin(port_d_oe, 8'hff);
        cmp_pin(port_d_out, v);
      end
    join
    repeat (2) @(posedge sys_clk);
    rd(OFF_SLAVE_CTL, 8'hb0);
    taken <= 1'b1;
    @(posedge sys_clk);
    taken <= 1'b0;
    wr(OFF_SLAVE_CTL, 8'h10);
    rd(OFF_SLAVE_CTL, 8'h10);
    tally_and_finish();
  end
endmodule
